//--- logic/dfts_defines.svh
// Constants for the drive fault trip supervisor
`ifndef DFTS_DEFINES_SVH
`define DFTS_DEFINES_SVH
// Register byte addresses
`define DFTS_ADDR_INSEL      8'h00
`define DFTS_ADDR_REFCFG     8'h04
`define DFTS_ADDR_RELAY      8'h08
`define DFTS_ADDR_MOTOR_OL   8'h0c
`define DFTS_ADDR_CONTROL    8'h10
`define DFTS_ADDR_STATUS     8'h14
`define DFTS_ADDR_CAUSE      8'h18
`define DFTS_ADDR_MEAS       8'h1c
// Input function codes
`define DFTS_FN_EXT_NO       5'h12
`define DFTS_FN_EXT_NC       5'h13
`define DFTS_FN_MAX          5'h18
// Relay function codes
`define DFTS_RLY_DRV_OL      5'h06
`define DFTS_RLY_REF_LOSS    5'h0b
`define DFTS_RLY_FAULT       5'h11
`define DFTS_RLY_MAX         5'h12
// Reset values
`define DFTS_RST_INSEL       25'h0000000
`define DFTS_RST_WAIT        11'h00a
`define DFTS_RST_RELAY       5'h11
`define DFTS_RST_MOTOR_OL    8'hb4
`define DFTS_RST_VMIN        8'h00
// Current and voltage thresholds (percent of rating, volts)
`define DFTS_OC_PCT          8'hc8
`define DFTS_DRV_OL_PCT      8'h96
`define DFTS_OV_VOLT         10'h190
`define DFTS_UV_VOLT         10'h0b4
// Timing: 0.1 s tick at 200 MHz, drive overload budget 600 ticks at 150%
`define DFTS_CLK_HZ          200000000
`define DFTS_TICK_MS         100
`define DFTS_TICK_CYC        ((`DFTS_CLK_HZ / 1000) * `DFTS_TICK_MS)
`define DFTS_WAIT_MAX        11'h4b0
`define DFTS_OL_BUDGET       24'h00ea60
`define DFTS_OL_GAIN         24'h000002
`define DFTS_CAP_BUDGET      24'h000c80
// Cause bit positions
`define DFTS_C_EXT           0
`define DFTS_C_ESTOP         1
`define DFTS_C_REFLOSS       2
`define DFTS_C_DRV_OL        3
`define DFTS_C_OC            4
`define DFTS_C_OV            5
`define DFTS_C_UV            6
`define DFTS_C_PHLOSS        7
`define DFTS_C_GND           8
`define DFTS_C_MOTOR_OL      9
`define DFTS_C_HEAT          10
`define DFTS_C_CAP           11
`define DFTS_C_SAVE          12
`define DFTS_C_HW            13
`define DFTS_C_INPH          14
`define DFTS_NCAUSE          15
`endif

//--- logic/dfts_pkg.sv
// Types for the drive fault trip supervisor
package dfts_pkg;
    typedef enum logic [3:0] {
        DFTS_RUN    = 4'h1,
        DFTS_ESTOP  = 4'h2,
        DFTS_DECEL  = 4'h4,
        DFTS_TRIP   = 4'h8
    } dfts_mode_e;
    typedef enum logic [1:0] {
        DFTS_LOSS_OFF  = 2'h0,
        DFTS_LOSS_HALF = 2'h1,
        DFTS_LOSS_MIN  = 2'h2
    } dfts_crit_e;
    typedef enum logic [1:0] {
        DFTS_REACT_HOLD  = 2'h0,
        DFTS_REACT_FREE  = 2'h1,
        DFTS_REACT_DECEL = 2'h2
    } dfts_react_e;
endpackage

//--- logic/dfts_supervisor.sv
// Drive fault trip supervisor with AXI4-Lite register access
//
// Overview of operation
// - Function 18: closed contact trips externally
// - Function 19: opened contact trips externally
// - Five terminals each own function selector
// - Criterion 0 off, 1 half, 2 minimum
// - Loss checked only for analog/serial reference
// - Loss reacts after wait held, 0.1s steps
// - Reaction 0 hold, 1 free run, 2 decel
// - Relay code 11 shows reference loss
// - Drive overload: 150% for minute, inverse time
// - Relay code 6 shows drive overload
// - Overcurrent above 200% trips
// - Bus above 400 V trips
// - Bus below 180 V trips
// - Emergency stop cuts output immediately
// - Release resumes if run input held
// - Hardware fault clears only at power-down
// - Save failure flags parameter save error
// - Open output phase trips
// - Ground fault: unbalance plus overcurrent trips
// - Motor overload threshold exceeded trips
// - Heat-sink overheat trips
// - Capacitor ripple trips, current-dependent time
// - Mask bits: 2 output, 4 input, 8 ground
`timescale 1ns/1ps
`include "dfts_defines.svh"

module dfts_supervisor
    import dfts_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Contact pins, closed to input_common reads high
    input  wire logic [4:0]  input_terminal,
    input  wire logic        emergency_stop_input,
    input  wire logic        forward_run_input,
    input  wire logic        reverse_run_input,
    input  wire logic        reset_input,
    // Measurements and comparator flags from the analog front end
    input  wire logic [7:0]  output_current_pct,
    input  wire logic [9:0]  dc_bus_volt,
    input  wire logic [7:0]  ref_level_pct,
    input  wire logic        ref_is_current,
    input  wire logic        ref_source_ext,
    input  wire logic        serial_ref_valid,
    input  wire logic [2:0]  phase_open,
    input  wire logic        phase_unbalance,
    input  wire logic        input_phase_loss,
    input  wire logic        heatsink_overheat,
    input  wire logic        bus_ripple_high,
    input  wire logic        save_fail,
    input  wire logic        cpu_fault,
    // Outputs
    output logic             output_enable,
    output logic             decel_request,
    output logic             hold_frequency,
    output logic             fault_active,
    output logic             param_save_error,
    output logic             relay_contact_no,
    output logic             relay_contact_nc
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [4:0]  s1_pins;
        logic [4:0]  s2_pins;
        logic [4:0]  s1_ctl;
        logic [4:0]  s2_ctl;
        logic [24:0] insel;
        logic [1:0]  crit;
        logic [1:0]  react;
        logic [10:0] wait_t;
        logic [7:0]  vmin;
        logic [7:0]  imin;
        logic [4:0]  relay_sel;
        logic [7:0]  motor_ol;
        logic [2:0]  fmask;
        logic        sw_reset;
        logic [14:0] cause;
        dfts_mode_e  mode;
        logic        ref_lost;
        logic [24:0] tick_cnt;
        logic [10:0] loss_cnt;
        logic [23:0] ol_acc;
        logic [23:0] cap_acc;
        logic        estop_lvl;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        relay;
    } dfts_state_s;

    dfts_state_s st_r;
    dfts_state_s st_nxt;

    // Register read decode, used by the read channel
    function automatic logic [32:0] reg_read(input dfts_state_s s, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        case (a)
            `DFTS_ADDR_INSEL:    r = {1'b0, 7'h00, s.insel};
            `DFTS_ADDR_REFCFG:   r = {1'b0, s.imin, s.vmin, 1'b0, s.wait_t, s.react, s.crit};
            `DFTS_ADDR_RELAY:    r = {1'b0, 27'h0000000, s.relay_sel};
            `DFTS_ADDR_MOTOR_OL: r = {1'b0, 24'h000000, s.motor_ol};
            `DFTS_ADDR_CONTROL:  r = {1'b0, 28'h0000000, s.fmask, 1'b0};
            `DFTS_ADDR_STATUS:   r = {1'b0, 24'h000000, s.relay, s.ref_lost, 2'h0, s.mode};
            `DFTS_ADDR_CAUSE:    r = {1'b0, 17'h00000, s.cause};
            `DFTS_ADDR_MEAS:     r = {1'b0, 6'h00, s.cap_acc[23:16], s.ol_acc[23:6]};
            default:             r = {1'b1, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // Byte-lane merge of write data
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Function code of one terminal
    function automatic logic [4:0] fn_of(input logic [24:0] sel, input int i);
        return sel[i*5 +: 5];
    endfunction

    // =====================================================================
    // Next-state logic
    // =====================================================================
    logic [4:0]  pins;
    logic        estop;
    logic        run_cmd;
    logic        rst_evt;
    logic        ext_trip;
    logic        ref_low;
    logic        loss_cond;
    logic        wr_go;
    logic [32:0] rd;
    logic [31:0] wv;
    logic [14:0] cond;
    logic [14:0] clearable;
    logic [23:0] ol_step;
    logic        tick;
    logic        drv_ol_cond;
    logic        cap_cond;

    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers on contact pins
        st_nxt.s1_pins = input_terminal;
        st_nxt.s2_pins = st_r.s1_pins;
        st_nxt.s1_ctl  = {emergency_stop_input, forward_run_input, reverse_run_input,
                          reset_input, 1'b0};
        st_nxt.s2_ctl  = st_r.s1_ctl;
        pins    = st_r.s2_pins;
        estop   = st_r.s2_ctl[4];
        run_cmd = st_r.s2_ctl[3] | st_r.s2_ctl[2];
        rst_evt = st_r.s2_ctl[1] | st_r.sw_reset;
        st_nxt.sw_reset = 1'b0;

        // 0.1 s tick divider
        tick = (st_r.tick_cnt == 25'(`DFTS_TICK_CYC - 1));
        st_nxt.tick_cnt = tick ? 25'h0000000 : st_r.tick_cnt + 25'h0000001;

        // External trip terminals, each with its own selector
        ext_trip = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (fn_of(st_r.insel, i) == `DFTS_FN_EXT_NO && pins[i]) begin
                ext_trip = 1'b1;
            end
            if (fn_of(st_r.insel, i) == `DFTS_FN_EXT_NC && !pins[i]) begin
                ext_trip = 1'b1;
            end
        end

        // Reference loss criterion and wait
        case (st_r.crit)
            DFTS_LOSS_HALF: ref_low = ref_level_pct < ((ref_is_current ? st_r.imin
                                                       : st_r.vmin) >> 1);
            DFTS_LOSS_MIN:  ref_low = ref_level_pct < (ref_is_current ? st_r.imin
                                                       : st_r.vmin);
            default:        ref_low = 1'b0;
        endcase
        loss_cond = ref_source_ext && st_r.crit != DFTS_LOSS_OFF
                    && (ref_low || !serial_ref_valid);
        if (!loss_cond) begin
            st_nxt.loss_cnt = 11'h000;
            st_nxt.ref_lost = 1'b0;
        end else if (tick && !st_r.ref_lost) begin
            st_nxt.loss_cnt = st_r.loss_cnt + 11'h001;
            if (st_r.loss_cnt + 11'h001 >= st_r.wait_t) begin
                st_nxt.ref_lost = 1'b1;
            end
        end

        // Drive overload: excess over 100% integrated, budget at 150% for 60 s
        ol_step = (output_current_pct > 8'h64) ? 24'(output_current_pct - 8'h64)
                                               : 24'h000000;
        if (tick) begin
            st_nxt.ol_acc = (ol_step == 24'h000000) ? 24'h000000
                            : st_r.ol_acc + ol_step * `DFTS_OL_GAIN;
        end
        drv_ol_cond = st_r.ol_acc >= `DFTS_OL_BUDGET;

        // Capacitor ripple: accumulate faster with current
        if (!bus_ripple_high) begin
            st_nxt.cap_acc = 24'h000000;
        end else if (tick) begin
            st_nxt.cap_acc = st_r.cap_acc + 24'(output_current_pct) + 24'h000001;
        end
        cap_cond = bus_ripple_high && st_r.cap_acc >= `DFTS_CAP_BUDGET;

        // Fault conditions
        cond = '0;
        cond[`DFTS_C_EXT]      = ext_trip;
        cond[`DFTS_C_REFLOSS]  = st_r.ref_lost && st_r.react == DFTS_REACT_FREE;
        cond[`DFTS_C_DRV_OL]   = drv_ol_cond;
        cond[`DFTS_C_OC]       = output_current_pct > `DFTS_OC_PCT;
        cond[`DFTS_C_OV]       = dc_bus_volt > `DFTS_OV_VOLT;
        cond[`DFTS_C_UV]       = dc_bus_volt < `DFTS_UV_VOLT;
        cond[`DFTS_C_PHLOSS]   = st_r.fmask[0] && st_r.mode == DFTS_RUN
                                 && (|phase_open);
        cond[`DFTS_C_INPH]     = st_r.fmask[1] && input_phase_loss;
        cond[`DFTS_C_GND]      = st_r.fmask[2] && st_r.mode == DFTS_RUN
                                 && phase_unbalance && cond[`DFTS_C_OC];
        cond[`DFTS_C_MOTOR_OL] = output_current_pct > st_r.motor_ol;
        cond[`DFTS_C_HEAT]     = heatsink_overheat;
        cond[`DFTS_C_CAP]      = cap_cond;
        cond[`DFTS_C_SAVE]     = save_fail;
        cond[`DFTS_C_HW]       = cpu_fault;

        // Latch; reset clears only causes whose condition has gone, never hardware
        clearable = ~cond;
        clearable[`DFTS_C_HW]    = 1'b0;
        clearable[`DFTS_C_ESTOP] = 1'b1;
        st_nxt.cause = st_r.cause | cond;
        if (rst_evt) begin
            st_nxt.cause = (st_r.cause & ~clearable) | cond;
        end

        // Operating mode
        case (st_r.mode)
            DFTS_RUN: begin
                if (estop) begin
                    st_nxt.mode = DFTS_ESTOP;
                end else if (st_r.ref_lost && st_r.react == DFTS_REACT_DECEL) begin
                    st_nxt.mode = DFTS_DECEL;
                end
            end
            DFTS_ESTOP: begin
                if (!estop && run_cmd) begin
                    st_nxt.mode = DFTS_RUN;
                end
            end
            DFTS_DECEL: begin
                if (estop) begin
                    st_nxt.mode = DFTS_ESTOP;
                end else if (!st_r.ref_lost) begin
                    st_nxt.mode = DFTS_RUN;
                end
            end
            DFTS_TRIP: begin
                if (st_nxt.cause == '0) begin
                    st_nxt.mode = estop ? DFTS_ESTOP : DFTS_RUN;
                end
            end
            default: st_nxt.mode = DFTS_TRIP;
        endcase
        if (st_nxt.cause != '0) begin
            st_nxt.mode = DFTS_TRIP;
        end

        // Relay function
        case (st_r.relay_sel)
            `DFTS_RLY_DRV_OL:   st_nxt.relay = st_r.cause[`DFTS_C_DRV_OL];
            `DFTS_RLY_REF_LOSS: st_nxt.relay = st_r.ref_lost;
            `DFTS_RLY_FAULT:    st_nxt.relay = |st_r.cause;
            default:            st_nxt.relay = 1'b0;
        endcase

        // AXI4-Lite write path: address and data taken in either order
        if (s_axi_awvalid && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        if (wr_go) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = 2'h0;
            case (st_r.aw_addr)
                `DFTS_ADDR_INSEL: begin
                    wv = merge({7'h00, st_r.insel}, st_r.w_data, st_r.w_strb);
                    st_nxt.insel = wv[24:0];
                    for (int i = 0; i < 5; i++) begin
                        if (wv[i*5 +: 5] > `DFTS_FN_MAX) begin
                            st_nxt.insel = st_r.insel;
                            st_nxt.bresp = 2'h2;
                        end
                    end
                end
                `DFTS_ADDR_REFCFG: begin
                    wv = merge({st_r.imin, st_r.vmin, 1'b0, st_r.wait_t, st_r.react,
                                st_r.crit}, st_r.w_data, st_r.w_strb);
                    if (wv[1:0] > 2'h2 || wv[3:2] > 2'h2 || wv[14:4] == 11'h000
                        || wv[14:4] > `DFTS_WAIT_MAX) begin
                        st_nxt.bresp = 2'h2;
                    end else begin
                        st_nxt.crit   = wv[1:0];
                        st_nxt.react  = wv[3:2];
                        st_nxt.wait_t = wv[14:4];
                        st_nxt.vmin   = wv[23:16];
                        st_nxt.imin   = wv[31:24];
                    end
                end
                `DFTS_ADDR_RELAY: begin
                    wv = merge({27'h0000000, st_r.relay_sel}, st_r.w_data, st_r.w_strb);
                    if (wv[4:0] > `DFTS_RLY_MAX) begin
                        st_nxt.bresp = 2'h2;
                    end else begin
                        st_nxt.relay_sel = wv[4:0];
                    end
                end
                `DFTS_ADDR_MOTOR_OL: begin
                    wv = merge({24'h000000, st_r.motor_ol}, st_r.w_data, st_r.w_strb);
                    st_nxt.motor_ol = wv[7:0];
                end
                `DFTS_ADDR_CONTROL: begin
                    wv = merge({28'h0000000, st_r.fmask, 1'b0}, st_r.w_data, st_r.w_strb);
                    st_nxt.sw_reset = wv[0];
                    st_nxt.fmask    = wv[3:1];
                end
                `DFTS_ADDR_STATUS, `DFTS_ADDR_CAUSE, `DFTS_ADDR_MEAS: begin
                    wv = st_r.w_data;
                end
                default: begin
                    wv = st_r.w_data;
                    st_nxt.bresp = 2'h3;
                end
            endcase
        end else begin
            wv = 32'h0000_0000;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // AXI4-Lite read path
        rd = reg_read(st_r, s_axi_araddr);
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd[31:0];
            st_nxt.rresp  = rd[32] ? 2'h3 : 2'h0;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r           <= '0;
            st_r.insel     <= `DFTS_RST_INSEL;
            st_r.wait_t    <= `DFTS_RST_WAIT;
            st_r.vmin      <= `DFTS_RST_VMIN;
            st_r.imin      <= `DFTS_RST_VMIN;
            st_r.relay_sel <= `DFTS_RST_RELAY;
            st_r.motor_ol  <= `DFTS_RST_MOTOR_OL;
            st_r.mode      <= DFTS_ESTOP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign s_axi_awready    = !st_r.aw_held;
    assign s_axi_wready     = !st_r.w_held;
    assign s_axi_bvalid     = st_r.bvalid;
    assign s_axi_bresp      = st_r.bresp;
    assign s_axi_arready    = !st_r.rvalid;
    assign s_axi_rvalid     = st_r.rvalid;
    assign s_axi_rdata      = st_r.rdata;
    assign s_axi_rresp      = st_r.rresp;
    assign output_enable    = (st_r.mode == DFTS_RUN) || (st_r.mode == DFTS_DECEL);
    assign decel_request    = st_r.mode == DFTS_DECEL;
    assign hold_frequency   = st_r.ref_lost && st_r.react == DFTS_REACT_HOLD;
    assign fault_active     = st_r.mode == DFTS_TRIP;
    assign param_save_error = st_r.cause[`DFTS_C_SAVE];
    assign relay_contact_no = st_r.relay;
    assign relay_contact_nc = !st_r.relay;

endmodule

//--- verif/dfts_supervisor_assertions.sv
// Port checker for the fault trip supervisor
`timescale 1ns/1ps
module dfts_supervisor_assertions (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic [7:0] output_current_pct,
    input wire logic [9:0] dc_bus_volt,
    input wire logic       heatsink_overheat,
    input wire logic       save_fail,
    input wire logic       cpu_fault,
    input wire logic       emergency_stop_input,
    input wire logic       forward_run_input,
    input wire logic       output_enable,
    input wire logic       fault_active,
    input wire logic       param_save_error,
    input wire logic       relay_contact_no,
    input wire logic       relay_contact_nc
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Output cut within the trip latency
    sequence s_off;
        ##[1:3] !output_enable;
    endsequence
    // Output back once the stop pin is released
    sequence s_on;
        ##[1:6] output_enable;
    endsequence
    oc_trip_a: assert property (output_current_pct > 8'hc8 |-> s_off)
        else $error("overcurrent kept output");
    ov_trip_a: assert property (dc_bus_volt > 10'h190 |-> s_off)
        else $error("over-voltage kept output");
    uv_trip_a: assert property (dc_bus_volt < 10'h0b4 |-> s_off)
        else $error("low voltage kept output");
    heat_trip_a: assert property (heatsink_overheat |-> s_off)
        else $error("overheat kept output");
    estop_cut_a: assert property (emergency_stop_input |-> ##[1:5] !output_enable)
        else $error("stop pin kept output");
    estop_resume_a: assert property (
        $fell(emergency_stop_input) && forward_run_input && !fault_active |-> s_on)
        else $error("no resume after stop");
    save_flag_a: assert property (save_fail |-> ##[1:3] param_save_error)
        else $error("save error not flagged");
    cpu_trip_a: assert property (cpu_fault |-> ##[1:3] fault_active)
        else $error("hardware fault not tripped");
    trip_hold_a: assert property (fault_active |-> !output_enable)
        else $error("output on during trip");
    relay_pair_a: assert property (relay_contact_no != relay_contact_nc)
        else $error("relay contacts not complementary");
endmodule
bind dfts_supervisor dfts_supervisor_assertions i_dfts_supervisor_assertions (.*);

//--- verif/dfts_partner.sv
// Contact and run-command model for the trip supervisor
`timescale 1ns/1ps
module dfts_partner (
    input wire logic       core_clk,
    input wire logic [1:0] run_req,
    input wire logic       trip_req,
    input wire logic       clr_req,
    output logic [4:0]     input_terminal,
    output logic           forward_run_input,
    output logic           reverse_run_input,
    output logic           reset_input
);
    initial {input_terminal, forward_run_input, reverse_run_input, reset_input} = 8'h80;
    // Contacts move just after the edge; reset only once the contact is healthy again
    always @(posedge core_clk) begin
        input_terminal <= {!trip_req, trip_req, 3'h0};
        forward_run_input <= run_req[0];
        reverse_run_input <= run_req[1];
        reset_input <= clr_req && input_terminal[4];
    end
endmodule

//--- verif/dfts_supervisor_test.sv
// Self-checking bench for the fault trip supervisor
`timescale 1ns/1ps
module dfts_supervisor_test;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} dfts_row_s;
    logic core_clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, emergency_stop_input = 0, save_fail = 0;
    logic heatsink_overheat = 0, cpu_fault = 0, phase_unbalance = 0, input_phase_loss = 0;
    logic trip_req = 0, clr_req = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, output_enable, decel_request, hold_frequency;
    logic fault_active, param_save_error, relay_contact_no, relay_contact_nc, reset_input;
    logic forward_run_input, reverse_run_input;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, output_current_pct = 8'h64;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [9:0] dc_bus_volt = 10'h12c;
    logic [4:0] input_terminal;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] phase_open = 0;
    logic [1:0] run_req = 0, s_axi_bresp, s_axi_rresp, resp, rr;
    wire [7:0] ref_level_pct = 8'h64;
    wire ref_is_current = 0, ref_source_ext = 0, serial_ref_valid = 1, bus_ripple_high = 0;
    int err_count = 0, checks_done = 0, cyc = 0;
    logic [31:0] cmask [4] = '{32'h20, 32'h40, 32'h400, 32'h1};
    dfts_row_s rows [4] = '{'{8'h08, 32'h06, 2'h0, 32'h06}, '{8'h08, 32'h13, 2'h2, 32'h06},
        '{8'h00, 32'h01390000, 2'h0, 32'h01390000}, '{8'h40, 32'h0, 2'h3, 32'h0}};
    dfts_supervisor i_dfts_supervisor (.*);
    dfts_partner i_dfts_partner (.*);
    initial forever #2.5 core_clk = ~core_clk;
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task summarize();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        resp = s_axi_bresp;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Main sequence
    initial begin
        settle(2);
        arst_n <= 1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(resp, rows[i].r);
            rd_reg(rows[i].a);
            chk(rd, rows[i].q);
            chk(rr, {2{rows[i].a == 8'h40}});
        end
        run_req <= 2'h1;
        settle(8);
        chk(output_enable, 1);
        chk({decel_request, hold_frequency}, 0);
        emergency_stop_input <= 1;
        settle(6);
        chk(output_enable, 0);
        emergency_stop_input <= 0;
        run_req <= 2'h2;
        settle(8);
        chk(output_enable, 1);
        output_current_pct <= 8'hc9;
        settle(6);
        chk(fault_active, 1);
        output_current_pct <= 8'h64;
        rd_reg(8'h18);
        chk(rd & 32'h10, 32'h10);
        chk(fault_active, 1);
        clr_req <= 1;
        settle(6);
        clr_req <= 0;
        chk(fault_active, 0);
        for (int i = 0; i < 4; i++) begin
            dc_bus_volt <= (i == 0) ? 10'h191 : (i == 1) ? 10'h0b3 : 10'h12c;
            heatsink_overheat <= (i == 2);
            trip_req <= (i == 3);
            settle(8);
            chk(fault_active, 1);
            rd_reg(8'h18);
            chk(rd & 32'h461, cmask[i]);
            chk(relay_contact_no, 0);
            dc_bus_volt <= 10'h12c;
            heatsink_overheat <= 0;
            trip_req <= 0;
            clr_req <= 1;
            settle(6);
            clr_req <= 0;
            chk(fault_active, 0);
        end
        wr(8'h10, 32'h2);
        phase_open <= 3'h1;
        settle(4);
        chk(fault_active, 1);
        phase_open <= 0;
        arst_n <= 0;
        settle(1);
        arst_n <= 1;
        rd_reg(8'h04);
        chk(rd, 32'ha0);
        rd_reg(8'h0c);
        chk(rd, 32'hb4);
        cpu_fault <= 1;
        save_fail <= 1;
        settle(1);
        cpu_fault <= 0;
        save_fail <= 0;
        settle(2);
        chk(param_save_error, 1);
        wr(8'h10, 32'h1);
        settle(4);
        chk(fault_active, 1);
        chk(param_save_error, 0);
        chk(relay_contact_no, 1);
        summarize();
    end
endmodule
